// *** cpu_model.sv ***
`timescale 1ns/100ps
module cpu_model (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        slow_i,   // Late take, lets the offer refresh
    input  wire logic        req_i,
    input  wire logic [15:0] vec_i,
    input  wire logic [15:0] hand_i,
    input  wire logic [5:0]  prio_i,
    output logic             ack_o,
    output logic             reti_o,
    output logic             busy_o,   // Handler running
    output logic [7:0]       taken_o,  // Offers taken so far
    output logic [15:0]      pc_o,     // Loaded program counter
    output logic [15:0]      vec_o,
    output logic [5:0]       prio_o
);
    logic [3:0] cnt_r;                 // Delay counter
    // Take an offer, run a short handler, then return
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {ack_o, reti_o, busy_o, taken_o, pc_o, vec_o, prio_o, cnt_r} <= '0;
        end else begin
            reti_o <= 1'b0;
            if (ack_o) begin           // Taken at this edge
                ack_o   <= 1'b0;
                busy_o  <= 1'b1;
                cnt_r   <= 4'h0;
                taken_o <= taken_o + 8'h01;
                pc_o    <= hand_i;
                vec_o   <= vec_i;
                prio_o  <= prio_i;
            end else if (busy_o) begin // Return after eleven cycles
                cnt_r <= cnt_r + 4'h1;
                if (cnt_r == 4'ha) begin
                    reti_o <= 1'b1;
                    busy_o <= 1'b0;
                end
            end else if (req_i && !reti_o) begin
                cnt_r <= cnt_r + 4'h1;
                if (!slow_i || cnt_r == 4'h8) begin
                    ack_o <= 1'b1;
                end
            end
        end
    end
endmodule : cpu_model

// *** interrupt_vector_priority.sv ***
// Function
// - Vectors live in words FF80h to FFFFh
// - Vector word holds 16-bit handler address
// - All reset causes use FFFEh, priority 63
// - System NMI causes use FFFCh, priority 62
// - Watchdog interval request uses FFEEh, priority 55
// - First serial events share FFECh, priority 54
// - Second serial events share FFEAh, priority 53
// - First port flags share FFE6h, priority 51
// - Second port flags share FFE4h, priority 50
// - Event wakes from low power, returns after
//
// Decided for this implementation: the address map and the Wishbone interface to the registers.
`timescale 1ns/100ps
module interrupt_vector_priority
    import irq_vec_pkg::*;
(
    input  wire logic             CLK_I,
    input  wire logic             RESETN_I,
    // Wishbone slave
    input  wire logic [ADR_W-1:0] ADR_I,
    input  wire logic [31:0]      DAT_I,
    output logic      [31:0]      DAT_O,
    input  wire logic             WE_I,
    input  wire logic [3:0]       SEL_I,
    input  wire logic             CYC_I,
    input  wire logic             STB_I,
    output logic                  ACK_O,
    // Request sources (levels)
    input  wire logic [7:0]       RESET_CAUSE_I,
    input  wire logic [4:0]       SYSTEM_NMI_I,
    input  wire logic             WATCHDOG_FLAG_I,
    input  wire logic [3:0]       SERIAL_A_EVENTS_I,
    input  wire logic [15:0]      SERIAL_B_EVENTS_I,
    input  wire logic [7:0]       PORT_ONE_CHANGE_FLAGS_I,
    input  wire logic [7:0]       PORT_TWO_CHANGE_FLAGS_I,
    // CPU vector fetch handshake
    output logic                  CPU_REQ_O,
    output logic      [15:0]      CPU_VEC_ADDR_O,
    output logic      [15:0]      CPU_HANDLER_O,
    output logic      [5:0]       CPU_PRIO_O,
    input  wire logic             CPU_ACK_I,
    input  wire logic             CPU_RETI_I,
    // Power state and interrupt line
    output logic                  CPU_OFF_O,
    output logic                  STANDBY_O,
    output logic                  IRQ_O
);

    // Arbiter connection
    irq_arb_if arb_bus ();

    // Control and status state
    logic [2:0]           ctrl_r;                          // GIE and low-power request
    logic [NSRC-1:0]      status_r;                        // Sticky source flags
    logic [NSRC-1:0]      mask_r;                          // Source enables
    logic                 gie_saved_r;                     // GIE before service
    lpm_t                 lpm_saved_r;                     // Mode to resume after return
    pwr_state_t           state_r;                         // Power / service state
    pwr_state_t           state_nxt;                       // Next state
    word_t                vec_table_r [TABLE_WORDS];       // Handler words

    // Bus state
    logic                 ack_r;                           // Acknowledge flop
    logic [31:0]          dat_r;                           // Read data flop
    logic                 bus_req;                         // Access in progress
    logic                 wr_take;                         // Write commits now
    logic [31:0]          rd_val;                          // Decoded read value
    logic [31:0]          wr_val;                          // Lane-merged write value

    // CPU request flops
    logic                 req_r;                           // Offer to CPU
    word_t                vaddr_r;                         // Offered vector word
    word_t                handler_r;                       // Offered handler
    prio_t                prio_r;                          // Offered priority
    src_idx_t             offer_src_r;                     // Source of the offer

    // Raw event levels per source
    logic [NSRC-1:0]      raw_evt;
    logic                 take;                            // CPU takes the offer

    // Per-source vector register codes
    logic [5:0]           sera_code;
    logic [5:0]           serb_code;
    logic [5:0]           port1_code;
    logic [5:0]           port2_code;
    logic [5:0]           rcause_code;

    // Arbitration
    irq_arbiter u_arb (
        .bus (arb_bus.arb)
    );

    // Combine each source's flags into one request line
    always_comb begin
        raw_evt             = '0;
        raw_evt[SRC_RESET]  = |RESET_CAUSE_I;
        raw_evt[SRC_SYSNMI] = |SYSTEM_NMI_I;
        raw_evt[SRC_WDT]    = WATCHDOG_FLAG_I;
        raw_evt[SRC_SERA]   = |SERIAL_A_EVENTS_I;
        raw_evt[SRC_SERB]   = |SERIAL_B_EVENTS_I;
        raw_evt[SRC_PORT1]  = |PORT_ONE_CHANGE_FLAGS_I;
        raw_evt[SRC_PORT2]  = |PORT_TWO_CHANGE_FLAGS_I;
    end

    // Source-identifying vector codes
    assign sera_code   = flag_code({12'h000, SERIAL_A_EVENTS_I});
    assign serb_code   = flag_code(SERIAL_B_EVENTS_I);
    assign port1_code  = flag_code({8'h00, PORT_ONE_CHANGE_FLAGS_I});
    assign port2_code  = flag_code({8'h00, PORT_TWO_CHANGE_FLAGS_I});
    assign rcause_code = flag_code({8'h00, RESET_CAUSE_I});

    // Feed the arbiter; masked maskables never compete
    assign arb_bus.pending    = status_r & (mask_r | ~SRC_MASKABLE);
    assign arb_bus.gie        = ctrl_r[CTRL_GIE];
    assign arb_bus.in_service = (state_r == ST_SERVICE);

    // Bus access decode
    assign bus_req = CYC_I && STB_I;
    assign wr_take = bus_req && WE_I && ack_r;
    assign take    = req_r && CPU_ACK_I;

    // Read multiplexer
    always_comb begin
        rd_val = 32'h0000_0000;
        if (ADR_I >= OFS_TABLE && ADR_I < OFS_TABLE + ADR_W'(TABLE_WORDS * 4)) begin
            rd_val = {16'h0000, vec_table_r[ADR_I[7:2]]};
        end else begin
            case (ADR_I)
                OFS_CTRL:    rd_val = {29'h0, ctrl_r};
                OFS_STATUS:  rd_val = {25'h0, status_r};
                OFS_MASK:    rd_val = {25'h0, mask_r};
                OFS_GRANT:   rd_val = {18'h0, state_r, 1'b0, offer_src_r, 2'b00, prio_r};
                OFS_SERA_V:  rd_val = {26'h0, sera_code};
                OFS_SERB_V:  rd_val = {26'h0, serb_code};
                OFS_PORT1_V: rd_val = {26'h0, port1_code};
                OFS_PORT2_V: rd_val = {26'h0, port2_code};
                OFS_RCAUSE:  rd_val = {26'h0, rcause_code};
                default:     rd_val = 32'h0000_0000;      // Unmapped reads zero
            endcase
        end
    end

    // Lane-merged write value for the addressed register
    assign wr_val = lane_merge(rd_val, DAT_I, SEL_I);

    // Acknowledge one cycle after the request, drop the cycle after
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= bus_req && !ack_r;
            // Capture read data while the request is held
            if (bus_req && !ack_r) begin
                dat_r <= WE_I ? 32'h0000_0000 : rd_val;
            end
        end
    end

    assign ACK_O = ack_r;
    assign DAT_O = dat_r;

    // Control register: global enable and low-power request
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            ctrl_r      <= CTRL_RESET;
            gie_saved_r <= 1'b0;
        end else begin
            if (take) begin
                // Taking a request clears global enable and wakes the core
                gie_saved_r                    <= ctrl_r[CTRL_GIE];
                ctrl_r[CTRL_GIE]               <= 1'b0;
                ctrl_r[CTRL_LPM_HI:CTRL_LPM_LO] <= LPM_ACTIVE;
            end else if (CPU_RETI_I && state_r == ST_SERVICE) begin
                // Return restores enable and the mode left
                ctrl_r[CTRL_GIE]               <= gie_saved_r;
                ctrl_r[CTRL_LPM_HI:CTRL_LPM_LO] <= lpm_saved_r;
            end else if (wr_take && ADR_I == OFS_CTRL) begin
                ctrl_r <= wr_val[2:0];
            end
        end
    end

    // Mask register
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            mask_r <= MASK_RESET;
        end else if (wr_take && ADR_I == OFS_MASK) begin
            mask_r <= wr_val[NSRC-1:0];
        end
    end

    // Sticky status: set wins over write-one-to-clear
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            status_r <= '0;
        end else begin
            if (wr_take && ADR_I == OFS_STATUS) begin
                status_r <= (status_r & ~wr_val[NSRC-1:0]) | raw_evt;
            end else begin
                status_r <= status_r | raw_evt;
            end
        end
    end

    // Level interrupt line from unmasked status
    assign IRQ_O = |(status_r & mask_r);

    // Vector table, writable only inside the region
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            for (int i = 0; i < TABLE_WORDS; i++) begin
                vec_table_r[i] <= TABLE_RESET;
            end
        end else if (wr_take && ADR_I >= OFS_TABLE && ADR_I < OFS_TABLE + ADR_W'(TABLE_WORDS * 4)) begin
            vec_table_r[ADR_I[7:2]] <= wr_val[15:0];
        end
    end

    // Offer the winning vector to the CPU
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            req_r       <= 1'b0;
            vaddr_r     <= REGION_HI;
            handler_r   <= TABLE_RESET;
            prio_r      <= '0;
            offer_src_r <= '0;
        end else if (take) begin
            // Withdraw once taken
            req_r <= 1'b0;
        end else begin
            req_r       <= arb_bus.grant_valid;
            offer_src_r <= arb_bus.grant_src;
            prio_r      <= SRC_PRIO[arb_bus.grant_src];
            vaddr_r     <= SRC_VEC[arb_bus.grant_src] & ~16'h0001;
            handler_r   <= vec_table_r[vec_slot(SRC_VEC[arb_bus.grant_src])];
        end
    end

    assign CPU_REQ_O      = req_r;
    assign CPU_VEC_ADDR_O = vaddr_r;
    assign CPU_HANDLER_O  = handler_r;
    assign CPU_PRIO_O     = prio_r;

    // Power / service sequencing
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (take) begin
                    state_nxt = ST_SERVICE;
                end else if (ctrl_r[CTRL_LPM_HI:CTRL_LPM_LO] != LPM_ACTIVE) begin
                    state_nxt = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                // Any granted request wakes the core
                if (take) begin
                    state_nxt = ST_SERVICE;
                end else if (ctrl_r[CTRL_LPM_HI:CTRL_LPM_LO] == LPM_ACTIVE) begin
                    // Software cleared the mode, core runs again
                    state_nxt = ST_RUN;
                end
            end
            ST_SERVICE: begin
                if (take) begin
                    state_nxt = ST_SERVICE;                // Reset preempts handler
                end else if (CPU_RETI_I) begin
                    state_nxt = (lpm_saved_r != LPM_ACTIVE) ? ST_SLEEP : ST_RUN;
                end
            end
            default: state_nxt = ST_RUN;
        endcase
    end

    // State register and saved mode
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            state_r     <= ST_RUN;
            lpm_saved_r <= LPM_ACTIVE;
        end else begin
            state_r <= state_nxt;
            if (take) begin
                // Keep the outer mode across a preempting reset
                if (state_r != ST_SERVICE) begin
                    lpm_saved_r <= lpm_t'(ctrl_r[CTRL_LPM_HI:CTRL_LPM_LO]);
                end
            end
        end
    end

    // Low-power outputs follow the state and the requested or saved mode
    always_ff @(posedge CLK_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            CPU_OFF_O <= 1'b0;
            STANDBY_O <= 1'b0;
        end else begin
            CPU_OFF_O <= (state_nxt == ST_SLEEP);
            STANDBY_O <= (state_nxt == ST_SLEEP) &&
                         (state_nxt == state_r ? lpm_saved_r == LPM_STANDBY || 
                          ctrl_r[CTRL_LPM_HI:CTRL_LPM_LO] == LPM_STANDBY
                          : (ctrl_r[CTRL_LPM_HI:CTRL_LPM_LO] == LPM_STANDBY ||
                             lpm_saved_r == LPM_STANDBY));
        end
    end

endmodule : interrupt_vector_priority

// *** irq_arb_if.sv ***
`timescale 1ns/100ps
interface irq_arb_if;
    import irq_vec_pkg::*;
    logic [NSRC-1:0] pending;                              // Latched requests
    logic            gie;                                  // Global enable
    logic            in_service;                           // Handler running
    logic            grant_valid;                          // A request wins
    src_idx_t        grant_src;                            // Winning source

    modport arb (input pending, input gie, input in_service, output grant_valid, output grant_src);
    modport ctl (output pending, output gie, output in_service, input grant_valid, input grant_src);
endinterface : irq_arb_if

// *** irq_arbiter.sv ***
`timescale 1ns/100ps
module irq_arbiter
    import irq_vec_pkg::*;
(
    irq_arb_if.arb bus
);

    // Highest numeric priority among eligible requests
    always_comb begin
        logic [NSRC-1:0] elig;
        prio_t           best;
        elig             = '0;
        best             = '0;
        bus.grant_valid  = 1'b0;
        bus.grant_src    = '0;
        for (int i = 0; i < NSRC; i++) begin
            // Maskable need global enable, others ignore it
            elig[i] = bus.pending[i] && (!SRC_MASKABLE[i] || bus.gie);
            // Only reset may preempt a running handler
            if (bus.in_service && i != SRC_RESET) begin
                elig[i] = 1'b0;
            end
            if (elig[i] && (!bus.grant_valid || SRC_PRIO[i] > best)) begin
                bus.grant_valid = 1'b1;
                bus.grant_src   = src_idx_t'(i);
                best            = SRC_PRIO[i];
            end
        end
    end

endmodule : irq_arbiter

// *** irq_vec_pkg.sv ***
package irq_vec_pkg;

    // Request sources, ranked order of the table below
    localparam int NSRC = 7;
    localparam int SRC_RESET  = 0;                         // All reset causes
    localparam int SRC_SYSNMI = 1;                         // System non-maskable
    localparam int SRC_WDT    = 2;                         // Watchdog interval
    localparam int SRC_SERA   = 3;                         // First serial unit
    localparam int SRC_SERB   = 4;                         // Second serial unit
    localparam int SRC_PORT1  = 5;                         // First port changes
    localparam int SRC_PORT2  = 6;                         // Second port changes

    typedef logic [5:0]  prio_t;                           // Priority number
    typedef logic [15:0] word_t;                           // Vector or handler word
    typedef logic [2:0]  src_idx_t;                        // Source index

    // Vector region bounds (word addresses)
    localparam word_t REGION_LO = 16'hff80;
    localparam word_t REGION_HI = 16'hffff;

    // Priority and vector word of each source
    localparam prio_t SRC_PRIO [NSRC] = '{6'h3f, 6'h3e, 6'h37, 6'h36, 6'h35, 6'h33, 6'h32};
    localparam word_t SRC_VEC  [NSRC] = '{16'hfffe, 16'hfffc, 16'hffee, 16'hffec,
                                          16'hffea, 16'hffe6, 16'hffe4};
    localparam logic [NSRC-1:0] SRC_MASKABLE = 7'h7c;      // Gated by global enable

    // Register map (byte offsets)
    localparam int ADR_W = 12;
    localparam logic [ADR_W-1:0] OFS_CTRL    = 12'h000;
    localparam logic [ADR_W-1:0] OFS_STATUS  = 12'h004;
    localparam logic [ADR_W-1:0] OFS_MASK    = 12'h008;
    localparam logic [ADR_W-1:0] OFS_GRANT   = 12'h00c;
    localparam logic [ADR_W-1:0] OFS_SERA_V  = 12'h010;
    localparam logic [ADR_W-1:0] OFS_SERB_V  = 12'h014;
    localparam logic [ADR_W-1:0] OFS_PORT1_V = 12'h018;
    localparam logic [ADR_W-1:0] OFS_PORT2_V = 12'h01c;
    localparam logic [ADR_W-1:0] OFS_RCAUSE  = 12'h020;
    localparam logic [ADR_W-1:0] OFS_TABLE   = 12'h100;    // 64 vector words
    localparam int TABLE_WORDS = 64;

    // Control register fields and reset values
    localparam int CTRL_GIE    = 0;
    localparam int CTRL_LPM_LO = 1;
    localparam int CTRL_LPM_HI = 2;
    localparam logic [2:0]      CTRL_RESET   = 3'h0;
    localparam logic [NSRC-1:0] MASK_RESET   = 7'h00;
    localparam word_t           TABLE_RESET  = 16'h0000;

    // Grant register fields
    localparam int GRANT_PRIO_LO = 0;
    localparam int GRANT_SRC_LO  = 8;
    localparam int GRANT_ST_LO   = 12;

    // Low-power request encoding
    typedef enum logic [1:0] {
        LPM_ACTIVE  = 2'b00,
        LPM_CPU_OFF = 2'b01,
        LPM_STANDBY = 2'b10
    } lpm_t;

    // Power / service sequencing states
    typedef enum logic [1:0] {
        ST_RUN     = 2'b00,
        ST_SLEEP   = 2'b01,
        ST_SERVICE = 2'b10
    } pwr_state_t;

    // Table slot of a word address in the vector region
    function automatic logic [5:0] vec_slot(input word_t addr);
        return addr[6:1];
    endfunction : vec_slot

    // Pending-flag vector code: lowest set flag n reads 2*(n+1), none reads 0
    function automatic logic [5:0] flag_code(input logic [15:0] flags);
        logic [5:0] code;
        code = 6'h00;
        for (int i = 15; i >= 0; i--) begin
            if (flags[i]) begin
                code = 6'((i + 1) * 2);
            end
        end
        return code;
    endfunction : flag_code

    // Byte-lane merge for bus writes
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction : lane_merge

endpackage : irq_vec_pkg

// *** ivp_chk.sv ***
`timescale 1ns/100ps
module ivp_chk
    import irq_vec_pkg::*;
(
    input wire logic             CLK_I,
    input wire logic             RESETN_I,
    input wire logic [ADR_W-1:0] ADR_I,
    input wire logic             WE_I,
    input wire logic             CYC_I,
    input wire logic             STB_I,
    input wire logic             ACK_O,
    input wire logic [31:0]      DAT_O,
    input wire logic [7:0]       RESET_CAUSE_I,
    input wire logic             CPU_REQ_O,
    input wire logic [15:0]      CPU_VEC_ADDR_O,
    input wire logic [5:0]       CPU_PRIO_O,
    input wire logic             CPU_ACK_I,
    input wire logic             CPU_OFF_O,
    input wire logic             STANDBY_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);
    a_ack_single: assert property (ACK_O |=> !ACK_O) else $error("ack held too long");
    a_ack_next: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O) else $error("ack late");
    a_unmapped_zero: assert property (ACK_O && !WE_I && ADR_I == 12'h0f0 |-> DAT_O == 32'h0)
        else $error("unmapped read not zero");
    a_vec_region: assert property (CPU_REQ_O |-> CPU_VEC_ADDR_O >= 16'hff80)
        else $error("vector outside region");
    a_reset_vec: assert property (CPU_REQ_O && CPU_PRIO_O == 6'h3f |-> CPU_VEC_ADDR_O == 16'hfffe)
        else $error("reset vector wrong");
    a_vec_pairs: assert property (CPU_REQ_O |-> {CPU_PRIO_O, CPU_VEC_ADDR_O} inside
        {22'h3ffffe, 22'h3efffc, 22'h37ffee, 22'h36ffec, 22'h35ffea, 22'h33ffe6, 22'h32ffe4})
        else $error("priority and vector do not pair");
    a_reset_wins: assert property (CPU_REQ_O && $past(RESET_CAUSE_I, 3) != 8'h00 |-> CPU_PRIO_O == 6'h3f)
        else $error("reset request not first");
    a_take_drops: assert property (CPU_REQ_O && CPU_ACK_I |=> !CPU_REQ_O) else $error("offer kept after take");
    a_take_wakes: assert property (CPU_REQ_O && CPU_ACK_I |=> !CPU_OFF_O)
        else $error("core not woken by take");
    a_standby_off: assert property (STANDBY_O |-> CPU_OFF_O) else $error("standby without cpu off");
endmodule : ivp_chk
bind interrupt_vector_priority ivp_chk i_ivp_chk (.CLK_I(CLK_I), .RESETN_I(RESETN_I), .ADR_I(ADR_I),
    .WE_I(WE_I), .CYC_I(CYC_I), .STB_I(STB_I), .ACK_O(ACK_O), .DAT_O(DAT_O), .RESET_CAUSE_I(RESET_CAUSE_I),
    .CPU_REQ_O(CPU_REQ_O), .CPU_VEC_ADDR_O(CPU_VEC_ADDR_O), .CPU_PRIO_O(CPU_PRIO_O),
    .CPU_ACK_I(CPU_ACK_I), .CPU_OFF_O(CPU_OFF_O), .STANDBY_O(STANDBY_O));

// *** tb_top.sv ***
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_top;
    import irq_vec_pkg::*;
    logic clk = 0, rst_n = 0, we = 0, cyc = 0, stb = 0, wdt = 0, slow = 0;
    logic [11:0] adr = '0;
    logic [31:0] wdat = '0, rdat, q;
    logic [3:0]  sel = '0, sa = '0;
    logic [7:0]  rc = '0, p1 = '0, p2 = '0, tk;
    logic [4:0]  nmi = '0;
    logic [15:0] sb = '0, vaddr, hand, mpc, mvec;
    logic [5:0]  prio, mprio;
    logic        ack, req, cack, reti, busy, coff, stby, irq;
    int          failures = 0, cmp_count = 0;
    interrupt_vector_priority i_interrupt_vector_priority (.CLK_I(clk), .RESETN_I(rst_n), .ADR_I(adr),
        .DAT_I(wdat), .DAT_O(rdat), .WE_I(we), .SEL_I(sel), .CYC_I(cyc), .STB_I(stb), .ACK_O(ack),
        .RESET_CAUSE_I(rc), .SYSTEM_NMI_I(nmi), .WATCHDOG_FLAG_I(wdt), .SERIAL_A_EVENTS_I(sa),
        .SERIAL_B_EVENTS_I(sb), .PORT_ONE_CHANGE_FLAGS_I(p1), .PORT_TWO_CHANGE_FLAGS_I(p2),
        .CPU_REQ_O(req), .CPU_VEC_ADDR_O(vaddr), .CPU_HANDLER_O(hand), .CPU_PRIO_O(prio), .CPU_ACK_I(cack),
        .CPU_RETI_I(reti), .CPU_OFF_O(coff), .STANDBY_O(stby), .IRQ_O(irq));
    cpu_model i_cpu_model (.clk_i(clk), .rst_n_i(rst_n), .slow_i(slow), .req_i(req), .vec_i(vaddr),
        .hand_i(hand), .prio_i(prio), .ack_o(cack), .reti_o(reti), .busy_o(busy), .taken_o(tk),
        .pc_o(mpc), .vec_o(mvec), .prio_o(mprio));
    initial forever #5 clk = ~clk;
    // Verdict and end of run
    task close_out;
        $display("counts cmp=%0d bad=%0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out
    // One classic bus cycle, waits for ack
    task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, 4'hf};
        @(posedge clk);
        while (ack !== 1'b1 && n < 20) begin @(posedge clk); n++; end
        if (n >= 20) begin failures++; close_out; end
        q = rdat;
        {cyc, stb, we} <= 3'b000;
        @(negedge clk);
    endtask : wb
    function automatic logic [15:0] hand_of(input int i);
        return 16'h4000 | 16'(i << 4);
    endfunction : hand_of
    // Drive one event line of source i
    task automatic set_src(input int i, input logic v);
        @(posedge clk);
        case (i)
            0: rc[2] <= v;
            1: nmi[4] <= v;
            2: wdt <= v;
            3: sa[1] <= v;
            4: sb[15] <= v;
            5: p1[3] <= v;
            default: p2[7] <= v;
        endcase
    endtask : set_src
    // Wait for a take, judge what the core loaded
    task automatic take(input int i);
        int n;
        logic [7:0] c;
        c = tk;
        n = 0;
        while (tk === c && n < 60) begin @(negedge clk); n++; end
        if (n >= 60) begin failures++; close_out; end
        `CHK("prio", SRC_PRIO[i], mprio)
        `CHK("vector", SRC_VEC[i], mvec)
        `CHK("handler", hand_of(i), mpc)
    endtask : take
    // Drop source, clear its status, wait for return
    task automatic clear(input int i, input logic xirq);
        int n;
        n = 0;
        set_src(i, 1'b0);
        wb(1'b1, OFS_STATUS, 32'h1 << i);
        while (busy !== 1'b0 && n < 40) begin @(negedge clk); n++; end
        if (n >= 40) begin failures++; close_out; end
        repeat (3) @(negedge clk);
        `CHK("irq", xirq, irq)
    endtask : clear
    task automatic t_regs;
        wb(1'b0, OFS_CTRL, 0); `CHK("ctrl", 32'h0, q)
        wb(1'b0, OFS_MASK, 0); `CHK("mask", 32'h0, q)
        wb(1'b0, OFS_TABLE, 0); `CHK("table", 32'h0, q)
        wb(1'b1, 12'h0f0, 32'hffffffff);
        wb(1'b0, 12'h0f0, 0); `CHK("unmapped", 32'h0, q)
        for (int i = 0; i < NSRC; i++) wb(1'b1, OFS_TABLE + 12'((SRC_VEC[i] - 16'hff80) << 1), 32'(hand_of(i)));
        $display("done t_regs");
    endtask : t_regs
    task automatic t_each; // every source in turn
        wb(1'b1, OFS_MASK, 32'h7f);
        wb(1'b1, OFS_CTRL, 32'h1);
        for (int i = 0; i < NSRC; i++) begin set_src(i, 1'b1); take(i); clear(i, 1'b0); end
        $display("done t_each");
    endtask : t_each
    task automatic t_prio; // three at once, slow take
        slow <= 1'b1;
        set_src(6, 1'b1);
        set_src(4, 1'b1);
        set_src(2, 1'b1);
        wb(1'b0, OFS_SERB_V, 0); `CHK("serb vec", 32'h20, q)
        take(2); clear(2, 1'b1); take(4); clear(4, 1'b1); take(6); clear(6, 1'b0);
        slow <= 1'b0;
        $display("done t_prio");
    endtask : t_prio
    task automatic t_gie; // global enable and mask
        wb(1'b1, OFS_MASK, 32'h0);
        wb(1'b1, OFS_CTRL, 32'h0);
        set_src(3, 1'b1);
        repeat (20) @(negedge clk);
        `CHK("no take", 8'd10, tk)
        `CHK("irq masked", 1'b0, irq)
        wb(1'b1, OFS_MASK, 32'h8); `CHK("irq", 1'b1, irq)
        wb(1'b1, OFS_CTRL, 32'h1);
        take(3); clear(3, 1'b0);
        $display("done t_gie");
    endtask : t_gie
    task automatic t_sleep; // standby, wake, back to standby
        wb(1'b1, OFS_MASK, 32'h7f);
        wb(1'b1, OFS_CTRL, 32'h5);
        @(negedge clk);
        `CHK("off", 1'b1, coff)
        `CHK("standby", 1'b1, stby)
        set_src(5, 1'b1);
        wb(1'b0, OFS_PORT1_V, 0); `CHK("port vec", 32'h8, q)
        take(5); `CHK("woken", 1'b0, coff)
        clear(5, 1'b0); `CHK("asleep", 1'b1, stby)
        wb(1'b1, OFS_CTRL, 32'h1);
        @(negedge clk); `CHK("awake", 1'b0, coff)
        @(posedge clk); rst_n <= 1'b0;
        @(posedge clk); rst_n <= 1'b1;
        wb(1'b0, OFS_CTRL, 0); `CHK("ctrl again", 32'h0, q)
        $display("done t_sleep");
    endtask : t_sleep
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        t_regs;
        t_each;
        t_prio;
        t_gie;
        t_sleep;
        close_out;
    end
endmodule : tb_top
